/* File: shared/fpes_pkg.sv */
// Shared constants and types of the flash program/erase sequencer and its host
// Behaviour
// - Bank erase leaves every bank bit one
// - Bank erase is setup 80h then D0h
// - Status bit 7 is ready, zero busy
// - Erase suspend sets bits 7 and 6
// - Bit 5 flags a bad command sequence
// - Bit 4 flags failed word program
// - Supply lockout sampled at start, bit 3
// - Program suspend sets bits 7 and 2
// - Protected target sets bit 1, aborts
// - Program is setup 40h/10h then data
// - One bank programs or is suspended, other reads
// - Busy bank reads return status
// - One onto zero: fail high, ignore normal
// - Reset pin low aborts running program
// - Error bits sticky until clear command
// - Busy bank takes only status and suspend
// - Per-block pin, lock, protect state
// - Blocks start protected and unlocked
// - Protect, unprotect, lock; 011 ignores all
// - Pin change moves pin bit; locks forced
// - Bad erase confirm sets bits 4, 5
`default_nettype none
package fpes_pkg;
	localparam int ADDR_W   = 4;
	localparam int DATA_W   = 16;
	localparam int NBANK    = 2;
	localparam int NBLK     = 4;
	localparam int DEPTH    = 16;
	localparam int BANK_BIT = 3;
	localparam int BLK_LSB  = 2;
	localparam int CNT_W    = 12;
	localparam logic [7:0] CMD_READ_ARRAY  = 8'hFF;
	localparam logic [7:0] CMD_STATUS_READ = 8'h70;
	localparam logic [7:0] CMD_SIG_READ    = 8'h90;
	localparam logic [7:0] CMD_STATUS_CLR  = 8'h50;
	localparam logic [7:0] CMD_BANK_ERASE  = 8'h80;
	localparam logic [7:0] CMD_CONFIRM     = 8'hD0;
	localparam logic [7:0] CMD_PROG_A      = 8'h40;
	localparam logic [7:0] CMD_PROG_B      = 8'h10;
	localparam logic [7:0] CMD_SUSPEND     = 8'hB0;
	localparam logic [7:0] CMD_PROT_SETUP  = 8'h60;
	localparam logic [7:0] CMD_PROTECT     = 8'h01;
	localparam logic [7:0] CMD_LOCK        = 8'h2F;
	localparam logic [1:0] SIG_PROT_WORD   = 2'h2;
	localparam int PROG_TIME_US  = 10;
	localparam int ERASE_TIME_US = 20;
	localparam int CLK_MHZ       = 125;
	localparam int PROG_CYC      = PROG_TIME_US * CLK_MHZ;
	localparam int ERASE_CYC     = ERASE_TIME_US * CLK_MHZ;
	localparam logic [NBLK-1:0] RST_PROT = 4'hF;
	localparam logic [NBLK-1:0] RST_LOCK = 4'h0;
	localparam logic [7:0] OFS_LINK_ADDR = 8'h00;
	localparam logic [7:0] OFS_LINK_DATA = 8'h04;
	localparam logic [7:0] OFS_CTRL      = 8'h08;
	localparam logic [7:0] OFS_STAT      = 8'h0C;
	localparam int CTRL_GO    = 0;
	localparam int CTRL_WRITE = 1;
	localparam int CTRL_RP    = 2;
	typedef enum logic [3:0] {
		P_NONE  = 4'h1,
		P_ERASE = 4'h2,
		P_PROG  = 4'h4,
		P_PROT  = 4'h8
	} fpes_pend_t;
	typedef enum logic [2:0] {
		M_ARRAY  = 3'h1,
		M_STATUS = 3'h2,
		M_SIG    = 3'h4
	} fpes_mode_t;
	typedef enum logic [4:0] {
		E_IDLE  = 5'h01,
		E_PROG  = 5'h02,
		E_ERASE = 5'h04,
		E_PSUSP = 5'h08,
		E_ESUSP = 5'h10
	} fpes_eng_t;
	typedef enum logic [1:0] {
		H_IDLE = 2'h1,
		H_WAIT = 2'h2
	} fpes_host_t;
endpackage
`default_nettype wire

/* File: shared/fpes_link_if.sv */
// Bus-cycle link between the flash command interface and its controller
`timescale 1ns/10ps
`default_nettype none
interface fpes_link_if;
	logic                          cyc_valid;
	logic                          cyc_write;
	logic [fpes_pkg::ADDR_W-1:0]   cyc_addr;
	logic [fpes_pkg::DATA_W-1:0]   cyc_wdata;
	logic [fpes_pkg::DATA_W-1:0]   cyc_rdata;
	logic                          cyc_ack;
	logic                          rp_n;
	modport dev (
		input  cyc_valid,
		input  cyc_write,
		input  cyc_addr,
		input  cyc_wdata,
		input  rp_n,
		output cyc_rdata,
		output cyc_ack
	);
	modport host (
		output cyc_valid,
		output cyc_write,
		output cyc_addr,
		output cyc_wdata,
		output rp_n,
		input  cyc_rdata,
		input  cyc_ack
	);
endinterface
`default_nettype wire

/* File: rtl/fpes_device.sv */
// Flash command interface, program/erase engine, status and block protection
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/10ps
`default_nettype none
module fpes_device #(
	parameter int PROG_CYC  = fpes_pkg::PROG_CYC,
	parameter int ERASE_CYC = fpes_pkg::ERASE_CYC
) (
	fpes_link_if.dev                     link,
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic                    wp_pin,
	input  wire logic                    vpp_low_pin,
	input  wire logic                    vpp_high_pin,
	output logic [fpes_pkg::NBANK-1:0]   bank_ready
);
	import fpes_pkg::*;

	function automatic logic bank_of(input logic [ADDR_W-1:0] a);
		return a[BANK_BIT];
	endfunction

	function automatic logic [NBANK-1:0] sel_of(input logic b);
		return NBANK'(1) << b;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	logic [2:0]        wp_sync_reg;
	logic [2:0]        lo_sync_reg;
	logic [2:0]        hi_sync_reg;
	logic              wp_reg;
	logic              wp_prev_reg;
	logic              vpp_low_reg;
	logic              vpp_high_reg;
	logic [DATA_W-1:0] mem_reg [DEPTH];
	logic [NBLK-1:0]   prot_reg;
	logic [NBLK-1:0]   lock_reg;
	logic [NBLK-1:0]   saved_reg;
	logic [NBANK-1:0]  ef_reg;
	logic [NBANK-1:0]  pf_reg;
	logic [NBANK-1:0]  lo_reg;
	logic [NBANK-1:0]  bp_reg;
	fpes_pend_t        pend_reg [NBANK];
	fpes_mode_t        mode_reg [NBANK];
	fpes_eng_t         eng_reg;
	logic              eng_bank_reg;
	logic [ADDR_W-1:0] eng_addr_reg;
	logic [DATA_W-1:0] eng_data_reg;
	logic [CNT_W-1:0]  cnt_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic              ack_reg;
	logic [NBANK-1:0]  ready_reg;

	// Pins settle through three stages; a level counts once the last two agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wp_sync_reg <= 3'h0;
			lo_sync_reg <= 3'h0;
			hi_sync_reg <= 3'h0;
			wp_reg <= 1'b0;
			vpp_low_reg <= 1'b0;
			vpp_high_reg <= 1'b0;
			wp_prev_reg <= 1'b0;
		end else begin
			wp_sync_reg <= {wp_sync_reg[1:0], wp_pin};
			lo_sync_reg <= {lo_sync_reg[1:0], vpp_low_pin};
			hi_sync_reg <= {hi_sync_reg[1:0], vpp_high_pin};
			if (wp_sync_reg[2] == wp_sync_reg[1])
				wp_reg <= wp_sync_reg[2];
			if (lo_sync_reg[2] == lo_sync_reg[1])
				vpp_low_reg <= lo_sync_reg[2];
			if (hi_sync_reg[2] == hi_sync_reg[1])
				vpp_high_reg <= hi_sync_reg[2];
			wp_prev_reg <= wp_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	logic              wr;
	logic              wb;
	logic [1:0]        blk;
	logic [7:0]        cmd;
	logic              run_here;
	logic              susp_here;
	logic              eng_idle;
	logic              start_prog;
	logic              start_erase;
	logic              do_susp;
	logic              do_resume;
	logic              seq_err;
	logic              set_lo;
	logic              set_bp;
	logic              clr;
	logic [2:0]        prot_op;
	logic              pend_we;
	logic              mode_we;
	fpes_pend_t        pend_next;
	fpes_mode_t        mode_next;

	assign wr = link.cyc_valid && link.cyc_write && link.rp_n;
	assign wb = bank_of(link.cyc_addr);
	assign blk = link.cyc_addr[ADDR_W-1:BLK_LSB];
	assign cmd = link.cyc_wdata[7:0];
	assign eng_idle = (eng_reg == E_IDLE);
	assign run_here = (eng_reg == E_PROG || eng_reg == E_ERASE) && eng_bank_reg == wb;
	assign susp_here = (eng_reg == E_PSUSP || eng_reg == E_ESUSP) && eng_bank_reg == wb;

	always_comb begin
		start_prog = 1'b0;
		start_erase = 1'b0;
		do_susp = 1'b0;
		do_resume = 1'b0;
		seq_err = 1'b0;
		set_lo = 1'b0;
		set_bp = 1'b0;
		clr = 1'b0;
		prot_op = 3'h0;
		pend_we = 1'b0;
		mode_we = 1'b0;
		pend_next = P_NONE;
		mode_next = M_STATUS;
		if (wr && run_here) begin
			if (cmd == CMD_STATUS_READ)
				mode_we = 1'b1;
			else if (cmd == CMD_SUSPEND)
				do_susp = 1'b1;
		end else if (wr) begin
			pend_we = 1'b1;
			case (pend_reg[wb])
				P_ERASE: begin
					mode_we = 1'b1;
					if (cmd != CMD_CONFIRM)
						seq_err = 1'b1;
					else if (!eng_idle)
						seq_err = 1'b0;
					else if (vpp_low_reg)
						set_lo = 1'b1;
					else if (|(prot_reg & (wb ? 4'hC : 4'h3)))
						set_bp = 1'b1;
					else
						start_erase = 1'b1;
				end
				P_PROG: begin
					mode_we = 1'b1;
					if (!eng_idle)
						seq_err = 1'b0;
					else if (vpp_low_reg)
						set_lo = 1'b1;
					else if (prot_reg[blk])
						set_bp = 1'b1;
					else
						start_prog = 1'b1;
				end
				P_PROT: begin
					if (cmd == CMD_PROTECT)
						prot_op = 3'h1;
					else if (cmd == CMD_CONFIRM)
						prot_op = 3'h2;
					else if (cmd == CMD_LOCK)
						prot_op = 3'h4;
					else
						seq_err = 1'b1;
				end
				default: begin
					case (cmd)
						CMD_BANK_ERASE: pend_next = eng_idle ? P_ERASE : P_NONE;
						CMD_PROG_A, CMD_PROG_B: pend_next = P_PROG;
						CMD_PROT_SETUP: pend_next = P_PROT;
						CMD_STATUS_CLR: begin
							clr = 1'b1;
							mode_we = 1'b1;
							mode_next = M_ARRAY;
						end
						CMD_READ_ARRAY: begin
							mode_we = 1'b1;
							mode_next = M_ARRAY;
						end
						CMD_STATUS_READ: mode_we = 1'b1;
						CMD_SIG_READ: begin
							mode_we = 1'b1;
							mode_next = M_SIG;
						end
						CMD_CONFIRM: begin
							do_resume = susp_here;
							mode_we = susp_here;
						end
						default: pend_next = P_NONE;
					endcase
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int b = 0; b < NBANK; b++) begin
				pend_reg[b] <= P_NONE;
				mode_reg[b] <= M_ARRAY;
			end
		end else if (!link.rp_n) begin
			for (int b = 0; b < NBANK; b++) begin
				pend_reg[b] <= P_NONE;
				mode_reg[b] <= M_ARRAY;
			end
		end else begin
			if (pend_we)
				pend_reg[wb] <= pend_next;
			if (mode_we)
				mode_reg[wb] <= mode_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	logic cnt_zero;
	logic prog_done;
	logic erase_done;
	logic prog_fail;

	assign cnt_zero = (cnt_reg == '0);
	assign prog_done = eng_reg == E_PROG && cnt_zero && !do_susp;
	assign erase_done = eng_reg == E_ERASE && cnt_zero && !do_susp;
	// A one over a programmed zero fails only at the high level, else it is dropped
	assign prog_fail = vpp_high_reg && |(eng_data_reg & ~mem_reg[eng_addr_reg]);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eng_reg <= E_IDLE;
			eng_bank_reg <= 1'b0;
			eng_addr_reg <= '0;
			eng_data_reg <= '0;
			cnt_reg <= '0;
		end else if (!link.rp_n) begin
			eng_reg <= E_IDLE;
		end else begin
			case (eng_reg)
				E_IDLE: begin
					if (start_prog || start_erase) begin
						eng_reg <= start_prog ? E_PROG : E_ERASE;
						eng_bank_reg <= wb;
						eng_addr_reg <= link.cyc_addr;
						eng_data_reg <= link.cyc_wdata;
						cnt_reg <= start_prog ? CNT_W'(PROG_CYC - 1) : CNT_W'(ERASE_CYC - 1);
					end
				end
				E_PROG, E_ERASE: begin
					if (do_susp)
						eng_reg <= (eng_reg == E_PROG) ? E_PSUSP : E_ESUSP;
					else if (cnt_zero)
						eng_reg <= E_IDLE;
					else
						cnt_reg <= cnt_reg - CNT_W'(1);
				end
				E_PSUSP: if (do_resume) eng_reg <= E_PROG;
				E_ESUSP: if (do_resume) eng_reg <= E_ERASE;
				default: eng_reg <= E_IDLE;
			endcase
		end
	end

	// Erase writes ones itself, so no pre-programming pass is needed from outside
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < DEPTH; i++)
				mem_reg[i] <= '1;
		end else if (prog_done) begin
			mem_reg[eng_addr_reg] <= mem_reg[eng_addr_reg] & eng_data_reg;
		end else if (erase_done) begin
			for (int i = 0; i < DEPTH; i++)
				if (bank_of(ADDR_W'(i)) == eng_bank_reg)
					mem_reg[i] <= '1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	logic [NBANK-1:0] wsel;
	logic [NBANK-1:0] clr_sel;

	assign wsel = sel_of(wb);
	assign clr_sel = {NBANK{clr}} & wsel;

	// Set is applied after clear, so an event in the clearing cycle survives
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ef_reg <= '0;
			pf_reg <= '0;
			lo_reg <= '0;
			bp_reg <= '0;
			ready_reg <= '1;
		end else begin
			ef_reg <= (ef_reg & ~clr_sel) | ({NBANK{seq_err}} & wsel);
			pf_reg <= (pf_reg & ~clr_sel) | ({NBANK{seq_err}} & wsel)
				| ({NBANK{prog_done && prog_fail}} & sel_of(eng_bank_reg));
			lo_reg <= (lo_reg & ~clr_sel) | ({NBANK{set_lo}} & wsel);
			bp_reg <= (bp_reg & ~clr_sel) | ({NBANK{set_bp}} & wsel);
			for (int b = 0; b < NBANK; b++)
				ready_reg[b] <= !((eng_reg == E_PROG || eng_reg == E_ERASE)
					&& eng_bank_reg == b[0]);
		end
	end

	function automatic logic [7:0] status_of(input logic b);
		logic run;
		logic own;
		run = eng_reg == E_PROG || eng_reg == E_ERASE;
		own = eng_bank_reg == b;
		return {!(run && own), eng_reg == E_ESUSP && own, ef_reg[b], pf_reg[b],
			lo_reg[b], eng_reg == E_PSUSP && own, bp_reg[b], 1'b0};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Pin edges move the pin bit; locked blocks are forced protected while low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prot_reg <= RST_PROT;
			lock_reg <= RST_LOCK;
			saved_reg <= RST_PROT;
		end else begin
			for (int k = 0; k < NBLK; k++) begin
				if (lock_reg[k] && wp_prev_reg && !wp_reg) begin
					saved_reg[k] <= prot_reg[k];
					prot_reg[k] <= 1'b1;
				end else if (lock_reg[k] && !wp_prev_reg && wp_reg) begin
					prot_reg[k] <= saved_reg[k];
				end
			end
			if (prot_op != 3'h0 && !(lock_reg[blk] && !wp_reg)) begin
				prot_reg[blk] <= !prot_op[1];
				if (prot_op[2])
					lock_reg[blk] <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	logic              rb;
	logic [DATA_W-1:0] rd_val;

	assign rb = bank_of(link.cyc_addr);

	always_comb begin
		rd_val = mem_reg[link.cyc_addr];
		if (mode_reg[rb] == M_STATUS || ((eng_reg == E_PROG || eng_reg == E_ERASE)
				&& eng_bank_reg == rb))
			rd_val = {8'h00, status_of(rb)};
		else if (mode_reg[rb] == M_SIG)
			rd_val = (link.cyc_addr[1:0] == SIG_PROT_WORD)
				? {14'h0000, lock_reg[blk], prot_reg[blk]} : 16'h0000;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_reg <= 1'b0;
			rdata_reg <= '0;
		end else begin
			ack_reg <= link.cyc_valid;
			rdata_reg <= (link.cyc_valid && !link.cyc_write) ? rd_val : '0;
		end
	end

	assign link.cyc_ack = ack_reg;
	assign link.cyc_rdata = rdata_reg;
	assign bank_ready = ready_reg;
endmodule
`default_nettype wire

/* File: rtl/fpes_host.sv */
// Controller end: APB registers that launch single bus cycles toward the flash
`timescale 1ns/10ps
`default_nettype none
module fpes_host (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	fpes_link_if.host        link
);
	import fpes_pkg::*;

	logic [ADDR_W-1:0] addr_reg;
	logic [DATA_W-1:0] data_reg;
	logic [DATA_W-1:0] cap_reg;
	logic              dir_reg;
	logic              rp_reg;
	logic              valid_reg;
	logic              pready_reg;
	logic              pslverr_reg;
	logic [31:0]       prdata_reg;
	fpes_host_t        state_reg;
	logic              done;
	logic              mapped;
	logic              go;

	// Slave answers one cycle into the access phase; effects land on that edge
	assign done = psel && penable && pready_reg;
	assign mapped = paddr == OFS_LINK_ADDR || paddr == OFS_LINK_DATA
		|| paddr == OFS_CTRL || paddr == OFS_STAT;
	assign go = done && pwrite && paddr == OFS_CTRL && pwdata[CTRL_GO];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= '0;
		end else begin
			pready_reg <= psel && penable && !pready_reg;
			pslverr_reg <= psel && penable && !pready_reg && !mapped;
			prdata_reg <= '0;
			if (psel && penable && !pready_reg && !pwrite) begin
				case (paddr)
					OFS_LINK_ADDR: prdata_reg <= {28'h0000000, addr_reg};
					OFS_LINK_DATA: prdata_reg <= {16'h0000, data_reg};
					OFS_CTRL: prdata_reg <= {29'h00000000, rp_reg, dir_reg, 1'b0};
					OFS_STAT: prdata_reg <= {cap_reg, 15'h0000, state_reg == H_WAIT};
					default: prdata_reg <= '0;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_reg <= '0;
			data_reg <= '0;
			dir_reg <= 1'b0;
			rp_reg <= 1'b1;
		end else if (done && pwrite) begin
			if (paddr == OFS_LINK_ADDR)
				addr_reg <= pwdata[ADDR_W-1:0];
			if (paddr == OFS_LINK_DATA)
				data_reg <= pwdata[DATA_W-1:0];
			if (paddr == OFS_CTRL) begin
				rp_reg <= pwdata[CTRL_RP];
				if (state_reg == H_IDLE)
					dir_reg <= pwdata[CTRL_WRITE];
			end
		end
	end

	// Software must order the two writes of each sequence; one cycle at a time
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= H_IDLE;
			valid_reg <= 1'b0;
			cap_reg <= '0;
		end else begin
			case (state_reg)
				H_IDLE: begin
					if (go) begin
						state_reg <= H_WAIT;
						valid_reg <= 1'b1;
					end
				end
				H_WAIT: begin
					valid_reg <= 1'b0;
					if (link.cyc_ack) begin
						state_reg <= H_IDLE;
						if (!dir_reg)
							cap_reg <= link.cyc_rdata;
					end
				end
				default: begin
					state_reg <= H_IDLE;
					valid_reg <= 1'b0;
				end
			endcase
		end
	end

	assign link.cyc_valid = valid_reg;
	assign link.cyc_write = dir_reg;
	assign link.cyc_addr = addr_reg;
	assign link.cyc_wdata = data_reg;
	assign link.rp_n = rp_reg;
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
endmodule
`default_nettype wire

/* File: tb/fpes_link_monitor.sv */
// Link checker: handshake timing and answer contents of the flash link
`timescale 1ns/10ps
`default_nettype none
module fpes_link_monitor (
	input wire logic                        pclk,
	input wire logic                        presetn,
	input wire logic                        cyc_valid,
	input wire logic                        cyc_write,
	input wire logic [fpes_pkg::ADDR_W-1:0] cyc_addr,
	input wire logic [fpes_pkg::DATA_W-1:0] cyc_wdata,
	input wire logic [fpes_pkg::DATA_W-1:0] cyc_rdata,
	input wire logic                        cyc_ack,
	input wire logic                        rp_n
);
	import fpes_pkg::*;
	logic [7:0] last_cmd_reg;
	logic       last_bank_reg;
	logic       rd_ack;
	logic       same_bank;
	assign rd_ack = cyc_ack && !cyc_write;
	assign same_bank = cyc_addr[BANK_BIT] == last_bank_reg;
	////////////////////////////////////////////////////////////////////////////////
	// Last command seen, so a read is judged by the mode it lands in
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_cmd_reg <= CMD_READ_ARRAY;
			last_bank_reg <= 1'b0;
		end else if (!rp_n) begin
			last_cmd_reg <= CMD_READ_ARRAY;
		end else if (cyc_valid && cyc_write) begin
			last_cmd_reg <= cyc_wdata[7:0];
			last_bank_reg <= cyc_addr[BANK_BIT];
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	property p_ack_follows; cyc_valid |=> cyc_ack; endproperty
	property p_ack_cause; cyc_ack |-> $past(cyc_valid); endproperty
	property p_ack_single; cyc_ack |=> !cyc_ack; endproperty
	property p_no_overlap; cyc_valid |-> !cyc_ack; endproperty
	property p_held;
		cyc_valid |=> $stable(cyc_addr) && $stable(cyc_wdata) && $stable(cyc_write);
	endproperty
	property p_rdata_idle; !cyc_ack |-> cyc_rdata == '0; endproperty
	property p_status_word;
		rd_ack && same_bank && last_cmd_reg == CMD_STATUS_READ
			|-> cyc_rdata[15:8] == 8'h00 && cyc_rdata[0] == 1'b0;
	endproperty
	// Only the protection word of a block carries state; other signature words read zero
	property p_sig_word;
		rd_ack && same_bank && last_cmd_reg == CMD_SIG_READ |-> cyc_rdata[15:2] == 14'h0000
			&& (cyc_addr[1:0] == SIG_PROT_WORD || cyc_rdata[1:0] == 2'b00);
	endproperty
	a_ack_follows: assert property (p_ack_follows)
		else $error("link cycle not answered one cycle later");
	a_ack_cause: assert property (p_ack_cause)
		else $error("link answer without a cycle");
	a_ack_single: assert property (p_ack_single)
		else $error("link answer longer than one cycle");
	a_no_overlap: assert property (p_no_overlap)
		else $error("new link cycle during an answer");
	a_held: assert property (p_held)
		else $error("link request changed before its answer");
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data outside an answer");
	a_status_word: assert property (p_status_word)
		else $error("status word has upper byte or bit 0 set");
	a_sig_word: assert property (p_sig_word)
		else $error("signature word carries stray bits");
	c_write: cover property (cyc_valid && cyc_write ##1 cyc_ack);
	c_status: cover property (rd_ack && same_bank && last_cmd_reg == CMD_STATUS_READ);
	c_sig: cover property (rd_ack && last_cmd_reg == CMD_SIG_READ && cyc_addr[1:0] == SIG_PROT_WORD);
endmodule
`default_nettype wire

/* File: tb/tb_flash_program_erase_status.sv */
// Bench: controller and flash joined over the link, driven through APB
`timescale 1ns/10ps
`default_nettype none
module tb_flash_program_erase_status;
	import fpes_pkg::*;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        wp_pin;
	logic        vpp_low_pin;
	logic        vpp_high_pin;
	logic [1:0]  bank_ready;
	logic [31:0] seed = 32'h0000_0CD4;
	logic [15:0] mem [16];
	logic [7:0]  st [2];
	int          prot [4];
	int          lock [4];
	int          sprot [4];
	int          n_mismatch = 0;
	int          total_checks = 0;
	logic [15:0] r;
	logic [15:0] d;
	logic [31:0] x;
	logic        e;
	fpes_link_if link ();
	fpes_device #(.PROG_CYC(200), .ERASE_CYC(300)) fpes_device_i (.link(link), .pclk(pclk),
		.presetn(presetn), .wp_pin(wp_pin), .vpp_low_pin(vpp_low_pin),
		.vpp_high_pin(vpp_high_pin), .bank_ready(bank_ready));
	fpes_host fpes_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(link));
	fpes_link_monitor mon_i (.pclk(pclk), .presetn(presetn), .cyc_valid(link.cyc_valid),
		.cyc_write(link.cyc_write), .cyc_addr(link.cyc_addr), .cyc_wdata(link.cyc_wdata),
		.cyc_rdata(link.cyc_rdata), .cyc_ack(link.cyc_ack), .rp_n(link.rp_n));
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic tmo();
		n_mismatch++;
		tally_and_finish();
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] ex);
		total_checks++;
		if (g !== ex) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, ex);
		end
	endtask
	// Gap cycle after each transfer keeps psel from being driven twice in one step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dd);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= dd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		x = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		if (n >= 20) tmo();
	endtask
	task automatic cyc(input logic w, input logic [3:0] a, input logic [15:0] dd);
		int n;
		apb(1'b1, OFS_LINK_ADDR, {28'h0, a});
		apb(1'b1, OFS_LINK_DATA, {16'h0, dd});
		apb(1'b1, OFS_CTRL, {29'h0, 1'b1, w, 1'b1});
		n = 0;
		do begin
			apb(1'b0, OFS_STAT, 32'h0);
			n++;
		end while (x[0] !== 1'b0 && n < 20);
		if (n >= 20) tmo();
		r = x[31:16];
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] dd);
		cyc(1'b1, a, dd);
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [15:0] ex);
		cyc(1'b0, a, 16'h0);
		chk(r, ex);
	endtask
	task automatic clr(input logic [3:0] a);
		wr(a, CMD_STATUS_CLR);
		st[a[3]] = 8'h00;
	endtask
	task automatic wait_rdy(input logic [3:0] a, input logic [15:0] ex);
		int n;
		wr(a, CMD_STATUS_READ);
		n = 0;
		do begin
			cyc(1'b0, a, 16'h0);
			n++;
		end while (r[7] !== 1'b1 && n < 60);
		if (n >= 60) tmo();
		chk(r, ex);
	endtask
	task automatic prog(input logic [7:0] c, input logic [3:0] a, input logic [15:0] dd);
		wr(a, {8'h00, c});
		wr(a, dd);
		if (vpp_low_pin) st[a[3]] |= 8'h08;
		else if (prot[a[3:2]] != 0) st[a[3]] |= 8'h02;
		else begin
			if (vpp_high_pin && (dd & ~mem[a]) != 16'h0) st[a[3]] |= 8'h10;
			mem[a] &= dd;
		end
		wait_rdy(a, {8'h00, st[a[3]] | 8'h80});
	endtask
	task automatic sig(input int b);
		wr(4'(b * 4), CMD_SIG_READ);
		rd_chk(4'(b * 4 + 2), {14'h0, 1'(lock[b]), 1'(prot[b])});
	endtask
	task automatic pcmd(input int b, input logic [7:0] c);
		wr(4'(b * 4), CMD_PROT_SETUP);
		wr(4'(b * 4), {8'h00, c});
		if (wp_pin || lock[b] == 0) begin
			if (c == CMD_LOCK) lock[b] = 1;
			prot[b] = (c != CMD_CONFIRM);
		end
		sig(b);
	endtask
	// Locked blocks save their protect bit on a falling pin and get it back on a rise
	task automatic setwp(input logic v);
		wp_pin <= v;
		repeat (6) @(posedge pclk);
		for (int i = 0; i < 4; i++) begin
			if (lock[i] != 0 && !v) sprot[i] = prot[i];
			if (lock[i] != 0) prot[i] = v ? sprot[i] : 1;
		end
		sig(1);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		wp_pin = 1'b0;
		vpp_low_pin = 1'b0;
		vpp_high_pin = 1'b0;
		for (int i = 0; i < 16; i++) mem[i] = 16'hFFFF;
		st[0] = 8'h00;
		st[1] = 8'h00;
		for (int i = 0; i < 4; i++) begin
			prot[i] = 1;
			lock[i] = 0;
			sprot[i] = 1;
		end
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		apb(1'b0, 8'h10, 32'h0);
		chk({31'h0, e}, 32'h1);
		for (int i = 0; i < 4; i++) sig(i);
		x = xs();
		prog(CMD_PROG_A, 4'h1, x[15:0]);
		clr(4'h1);
		rd_chk(4'h1, 16'hFFFF);
		pcmd(1, CMD_CONFIRM);
		pcmd(1, CMD_PROTECT);
		pcmd(1, CMD_CONFIRM);
		pcmd(1, CMD_LOCK);
		pcmd(1, CMD_CONFIRM);
		pcmd(0, CMD_CONFIRM);
		setwp(1'b1);
		pcmd(1, CMD_CONFIRM);
		setwp(1'b0);
		setwp(1'b1);
		// Program with suspend; busy bank must answer with status and drop other commands
		x = xs();
		d = x[15:0] & 16'hFFFE;
		wr(4'h8, CMD_READ_ARRAY);
		wr(4'h1, CMD_PROG_A);
		wr(4'h1, d);
		rd_chk(4'h1, 16'h0000);
		rd_chk(4'h8, 16'hFFFF);
		wr(4'h1, CMD_READ_ARRAY);
		rd_chk(4'h1, 16'h0000);
		wr(4'h1, CMD_SUSPEND);
		rd_chk(4'h1, 16'h0084);
		wr(4'h1, CMD_CONFIRM);
		mem[1] &= d;
		wait_rdy(4'h1, 16'h0080);
		wr(4'h1, CMD_READ_ARRAY);
		rd_chk(4'h1, mem[1]);
		vpp_high_pin <= 1'b1;
		prog(CMD_PROG_B, 4'h1, 16'hFFFF);
		vpp_high_pin <= 1'b0;
		prog(CMD_PROG_A, 4'h1, 16'hFFFF);
		clr(4'h1);
		rd_chk(4'h1, mem[1]);
		vpp_low_pin <= 1'b1;
		prog(CMD_PROG_A, 4'h2, 16'h0000);
		vpp_low_pin <= 1'b0;
		clr(4'h2);
		rd_chk(4'h2, 16'hFFFF);
		wr(4'h8, CMD_BANK_ERASE);
		wr(4'h8, CMD_CONFIRM);
		wait_rdy(4'h8, 16'h0082);
		clr(4'h8);
		wr(4'h8, CMD_BANK_ERASE);
		wr(4'h8, 16'h0000);
		wr(4'h8, CMD_STATUS_READ);
		rd_chk(4'h8, 16'h00B0);
		clr(4'h8);
		pcmd(2, CMD_CONFIRM);
		pcmd(3, CMD_CONFIRM);
		prog(CMD_PROG_A, 4'h9, 16'h0000);
		wr(4'h8, CMD_BANK_ERASE);
		wr(4'h8, CMD_CONFIRM);
		rd_chk(4'h8, 16'h0000);
		chk({30'h0, bank_ready}, 32'h1);
		wr(4'h8, CMD_SUSPEND);
		rd_chk(4'h8, 16'h00C0);
		wr(4'h8, CMD_CONFIRM);
		wait_rdy(4'h8, 16'h0080);
		wr(4'h8, CMD_READ_ARRAY);
		for (int i = 8; i < 16; i++) rd_chk(4'(i), 16'hFFFF);
		// Link reset in mid-program leaves the bank idle with clean flags
		wr(4'h2, CMD_PROG_A);
		wr(4'h2, 16'h0000);
		apb(1'b1, OFS_CTRL, 32'h0);
		apb(1'b1, OFS_CTRL, 32'h4);
		wr(4'h2, CMD_STATUS_READ);
		rd_chk(4'h2, 16'h0080);
		tally_and_finish();
	end
endmodule
`default_nettype wire
